/* dzt_pkg.sv */
// Constants shared by the distance zone trip logic
package dzt_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned NZONES = 6;
    localparam int unsigned NDELAYS = 9;
    localparam int unsigned ZN_FIRST = 0;
    localparam int unsigned ZN_SECOND = 1;
    localparam int unsigned ZN_THIRD = 2;
    localparam int unsigned ZN_FOURTH = 3;
    localparam int unsigned ZN_FIFTH = 4;
    localparam int unsigned ZN_OVERREACH = 5;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_DELAY0 = 12'h010;
    localparam int unsigned CTRL_SECOND_SP = 0;
    localparam int unsigned CTRL_OVR_FIRST_AR = 1;
    localparam int unsigned CTRL_OVR_SP_ONLY = 2;
    localparam int unsigned CTRL_OVR_2PH_SP = 3;
    localparam int unsigned CTRL_TELE_LSB = 4;
    localparam logic [5:0] CTRL_RESET = 6'h02;
    // Delay slots in ms: first 1p/mp, second 1p/mp, third, fourth, fifth, overreach 1p/mp
    localparam logic [NDELAYS*16-1:0] DELAY_RESET = {
        16'h0000, 16'h0000, 16'h0384, 16'h0384, 16'h0258,
        16'h012C, 16'h012C, 16'h0000, 16'h0000};
endpackage

/* dzt_trip.sv */
// Distance zone gating, delay timers and trip combination with an AHB-Lite register slave
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Any zone pickup raises general distance pickup
// - Per-zone per-phase fault detections feed logic
// - Gate detections, run zone timer, trip expiry
// - Single-pole only first, second, overreach with option
// - Per-pole trip events in single-pole zones
// - Separate single- and multi-phase delays there
// - Multi-phase and zones three-five trip three-pole
// - Single-pole trip needs external permit input
// - Energization signal bypasses zone delays
// - External blocks suppress fourth and fifth zones
// - Overreach enable or reclose enable activate overreach
// - Overreach enable only overreach; reclose enable shared
// - Overreach configurable single-pole faults only
// - Overreach may single-pole two-phase earthless faults
// - Teleprotection release only when scheme enabled
// - General trip when any zone trips
// - Per-phase single-pole outputs mean that pole only
// - Three-pole output when all poles open
// - Report tripping zone and single-pole possibility
// - Second zone single-pole needs setting, default no
// - Setting no holds overreach through first reclose
module dzt_trip
    import dzt_pkg::*;
#(
    parameter int unsigned TICK_DIV      = TICK_CYCLES,
    parameter bit          SP_OPTION     = 1'b1
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic [NZONES*3-1:0] zone_phase_detect,
    input  wire logic                earth_fault,
    input  wire logic                single_pole_trip_permit_in,
    input  wire logic                overreach_zone_enable_in,
    input  wire logic                reclose_zones_enable_in,
    input  wire logic                reclose_internal_release,
    input  wire logic                first_reclose_cycle,
    input  wire logic                teleprot_release,
    input  wire logic                energize_bypass,
    input  wire logic                fourth_zone_block,
    input  wire logic                fifth_zone_block,
    output logic                     distance_general_pickup,
    output logic                     distance_general_trip,
    output logic                     single_pole_trip_phase_a,
    output logic                     single_pole_trip_phase_b,
    output logic                     single_pole_trip_phase_c,
    output logic                     three_pole_trip,
    output logic [NZONES-1:0]        zone_trip_id,
    output logic [NZONES-1:0]        zone_single_pole_alarm,
    output logic                     reclose_stage_release
);

    typedef struct packed {
        logic [31:0]               pre;
        logic [NZONES-1:0][15:0]   tmr;
        logic [5:0]                ctrl;
        logic [NDELAYS-1:0][15:0]  dly;
        logic                      wr_pend;
        logic [11:0]               wr_addr;
        logic [31:0]               rdata;
        logic                      pickup;
        logic                      trip;
        logic [2:0]                sp;
        logic                      tp;
        logic [NZONES-1:0]         zid;
        logic [NZONES-1:0]         zsp;
    } dzt_state_t;

    dzt_state_t s_q;
    dzt_state_t s_d;

    // Zones that may trip single-pole at all
    function automatic logic sp_zone(input int unsigned z);
        sp_zone = (z == ZN_FIRST) || (z == ZN_SECOND) || (z == ZN_OVERREACH);
    endfunction

    // Delay slot used by a zone for a single- or multi-phase fault
    function automatic int unsigned delay_slot(input int unsigned z, input logic single);
        case (z)
            ZN_FIRST:     delay_slot = single ? 0 : 1;
            ZN_SECOND:    delay_slot = single ? 2 : 3;
            ZN_THIRD:     delay_slot = 4;
            ZN_FOURTH:    delay_slot = 5;
            ZN_FIFTH:     delay_slot = 6;
            default:      delay_slot = single ? 7 : 8;
        endcase
    endfunction

    function automatic logic [31:0] reg_read(input dzt_state_t s, input logic [11:0] a);
        int unsigned i;
        reg_read = 32'h0000_0000;
        if (a == OFS_CTRL) begin
            reg_read = {26'h0, s.ctrl};
        end else if (a == OFS_STATUS) begin
            reg_read = {14'h0, s.zsp, s.zid, s.tp, s.sp, s.trip, s.pickup};
        end else begin
            for (i = 0; i < NDELAYS; i++) begin
                if (a == OFS_DELAY0 + 12'(4 * i)) begin
                    reg_read = {16'h0, s.dly[i]};
                end
            end
        end
    endfunction

    logic [2:0]        ph [NZONES];
    logic [NZONES-1:0] det;
    logic [NZONES-1:0] single;
    logic [NZONES-1:0] zone_trip;
    logic [NZONES-1:0] zone_sp_ok;
    logic [2:0]        sp_ph;
    logic              tp_req;
    logic              ovr_active;
    logic              ar_release;
    logic              tick;
    logic              addr_ok;
    int unsigned       slot;

    always_comb begin
        s_d = s_q;
        sp_ph = 3'h0;
        tp_req = 1'b0;
        slot = 0;
        tick = (s_q.pre == TICK_DIV - 1);
        s_d.pre = tick ? 32'h0000_0000 : s_q.pre + 32'h0000_0001;
        // Reclose release is held off during the first cycle when disabled
        ar_release = (reclose_zones_enable_in || reclose_internal_release)
            && (s_q.ctrl[CTRL_OVR_FIRST_AR] || !first_reclose_cycle);
        ovr_active = overreach_zone_enable_in || ar_release
            || (teleprot_release && (s_q.ctrl[CTRL_TELE_LSB +: 2] != 2'h0));
        for (int unsigned z = 0; z < NZONES; z++) begin
            ph[z] = zone_phase_detect[3*z +: 3];
            single[z] = (ph[z] == 3'h1) || (ph[z] == 3'h2) || (ph[z] == 3'h4);
            det[z] = |ph[z];
            zone_sp_ok[z] = 1'b0;
            zone_trip[z] = 1'b0;
        end
        det[ZN_FOURTH] = det[ZN_FOURTH] && !fourth_zone_block;
        det[ZN_FIFTH] = det[ZN_FIFTH] && !fifth_zone_block;
        det[ZN_OVERREACH] = det[ZN_OVERREACH] && ovr_active
            && (!s_q.ctrl[CTRL_OVR_SP_ONLY] || single[ZN_OVERREACH]);
        for (int unsigned z = 0; z < NZONES; z++) begin
            slot = delay_slot(z, single[z]);
            // Timers count whole ms while the zone stays picked up and restart on drop-out
            if (!det[z]) begin
                s_d.tmr[z] = 16'h0000;
            end else if (tick && s_q.tmr[z] != 16'hFFFF) begin
                s_d.tmr[z] = s_q.tmr[z] + 16'h0001;
            end
            zone_trip[z] = det[z] && ((s_q.tmr[z] >= s_q.dly[slot]) || energize_bypass);
            zone_sp_ok[z] = SP_OPTION && sp_zone(z) && single_pole_trip_permit_in
                && (z != ZN_SECOND || s_q.ctrl[CTRL_SECOND_SP])
                && (single[z] || (z == ZN_OVERREACH && s_q.ctrl[CTRL_OVR_2PH_SP]
                    && !earth_fault && ph[z] != 3'h7));
            if (zone_trip[z]) begin
                if (zone_sp_ok[z]) begin
                    // Earthless two-phase trips the lowest-lettered phase of the pair only, so a for c-a
                    sp_ph = sp_ph | (ph[z] & (~ph[z] + 3'h1));
                end else begin
                    tp_req = 1'b1;
                end
            end
        end
        // Different poles asked by several zones cannot be a single-pole trip
        if (sp_ph != 3'h1 && sp_ph != 3'h2 && sp_ph != 3'h4) begin
            tp_req = tp_req || (sp_ph != 3'h0);
        end
        s_d.pickup = |det;
        s_d.trip = |zone_trip;
        s_d.tp = tp_req;
        s_d.sp = tp_req ? 3'h0 : sp_ph;
        s_d.zid = zone_trip;
        s_d.zsp = zone_trip & zone_sp_ok;
        // Bus slave: writes land in the data phase, reads are prepared from the address phase
        if (s_q.wr_pend) begin
            if (s_q.wr_addr == OFS_CTRL) begin
                s_d.ctrl = hwdata[5:0];
            end
            for (int unsigned i = 0; i < NDELAYS; i++) begin
                if (s_q.wr_addr == OFS_DELAY0 + 12'(4 * i)) begin
                    s_d.dly[i] = hwdata[15:0];
                end
            end
        end
        addr_ok = hsel && hready && htrans[1];
        s_d.wr_pend = addr_ok && hwrite;
        s_d.wr_addr = haddr[11:0];
        s_d.rdata = (addr_ok && !hwrite && haddr[31:12] == 20'h00000)
            ? reg_read(s_q, haddr[11:0]) : 32'h0000_0000;
        if (s_d.wr_pend && haddr[31:12] != 20'h00000) begin
            s_d.wr_pend = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RESET;
            s_q.dly <= DELAY_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign distance_general_pickup = s_q.pickup;
    assign distance_general_trip = s_q.trip;
    assign single_pole_trip_phase_a = s_q.sp[0];
    assign single_pole_trip_phase_b = s_q.sp[1];
    assign single_pole_trip_phase_c = s_q.sp[2];
    assign three_pole_trip = s_q.tp;
    assign zone_trip_id = s_q.zid;
    assign zone_single_pole_alarm = s_q.zsp;
    // Shared reclose release for any other function with a rapid reclose stage
    assign reclose_stage_release = reclose_zones_enable_in;

endmodule
`default_nettype wire

/* dzt_recloser.sv */
// Reclose equipment model driving the permit and reclose enable levels
`timescale 1ns/1ps
`default_nettype none
module dzt_recloser (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic sp_allow,
    input  wire logic ar_ready,
    output logic      single_pole_trip_permit_in,
    output logic      reclose_zones_enable_in
);
    // Contacts move just after an edge so the device never samples a change mid-edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) {single_pole_trip_permit_in, reclose_zones_enable_in} <= 2'b00;
        else {single_pole_trip_permit_in, reclose_zones_enable_in} <= {sp_allow, ar_ready};
    end
endmodule
`default_nettype wire

/* dzt_trip_properties.sv */
// Port assertions for the distance zone trip logic
`timescale 1ns/1ps
`default_nettype none
module dzt_trip_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [17:0] zone_phase_detect,
    input wire logic        single_pole_trip_permit_in,
    input wire logic        fourth_zone_block,
    input wire logic        distance_general_pickup,
    input wire logic        distance_general_trip,
    input wire logic        single_pole_trip_phase_a,
    input wire logic        single_pole_trip_phase_b,
    input wire logic        single_pole_trip_phase_c,
    input wire logic        three_pole_trip,
    input wire logic [5:0]  zone_trip_id,
    input wire logic [5:0]  zone_single_pole_alarm
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0] sp;
    assign sp = {single_pole_trip_phase_c, single_pole_trip_phase_b, single_pole_trip_phase_a};
    // Lone phase a fault in the first zone with the permit present
    sequence s_z1a; zone_phase_detect == 18'h00001 && single_pole_trip_permit_in; endsequence
    property p_pick; zone_phase_detect[2:0] != 3'h0 |=> distance_general_pickup; endproperty
    a_pick: assert property (p_pick) else $error("no pickup");
    property p_z1a; s_z1a |=> sp == 3'h1 && zone_trip_id[0] && !three_pole_trip; endproperty
    a_z1a: assert property (p_z1a) else $error("no pole a trip");
    property p_perm; sp != 3'h0 |-> $past(single_pole_trip_permit_in); endproperty
    a_perm: assert property (p_perm) else $error("pole trip without permit");
    property p_one; sp != 3'h0 |-> $onehot(sp) && !three_pole_trip; endproperty
    a_one: assert property (p_one) else $error("pole outputs clash");
    property p_gen; sp != 3'h0 || three_pole_trip |-> distance_general_trip; endproperty
    a_gen: assert property (p_gen) else $error("no general trip");
    property p_z345; zone_trip_id[4:2] != 3'h0 |-> three_pole_trip; endproperty
    a_z345: assert property (p_z345) else $error("grading zone not three-pole");
    property p_alm; zone_single_pole_alarm[4:2] == 3'h0; endproperty
    a_alm: assert property (p_alm) else $error("pole alarm from grading zone");
    property p_blk; fourth_zone_block |=> !zone_trip_id[3]; endproperty
    a_blk: assert property (p_blk) else $error("blocked zone tripped");
endmodule
bind dzt_trip dzt_trip_properties u_props (.*);
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the distance zone trip logic
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dzt_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rdp, sp_allow, ar_ready;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, r;
    logic [17:0] zone_phase_detect;
    logic [7:0]  sig;
    logic        earth_fault, overreach_zone_enable_in, reclose_internal_release, first_reclose_cycle;
    logic        teleprot_release, energize_bypass, fourth_zone_block, fifth_zone_block;
    logic        single_pole_trip_permit_in, reclose_zones_enable_in, reclose_stage_release;
    logic        distance_general_pickup, distance_general_trip, three_pole_trip;
    logic        single_pole_trip_phase_a, single_pole_trip_phase_b, single_pole_trip_phase_c;
    logic [5:0]  zone_trip_id, zone_single_pole_alarm;
    logic [63:0] q[$];
    logic [63:0] e;
    int          mismatches = 0, n_tests = 0;
    assign hready = hreadyout;
    assign {earth_fault, overreach_zone_enable_in, reclose_internal_release, first_reclose_cycle,
            teleprot_release, energize_bypass, fourth_zone_block, fifth_zone_block} = sig;
    dzt_trip #(.TICK_DIV(10)) uut (.*);
    dzt_recloser u_rc (.*);
    always #5 hclk = ~hclk;
    task automatic cmp(input logic [31:0] g, input logic [31:0] x, input logic [31:0] m);
        n_tests++;
        if ((g & m) !== (x & m)) begin
            mismatches++;
            $display("MISMATCH %0t got %h want %h", $time, g, x);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {3'b110, w, 20'h00000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {3'b000, d};
        do @(posedge hclk); while (hready !== 1'b1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
        q.push_back({m, x});
        xfer(1'b0, a, 32'h0);
    endtask
    // Hold a fault, read the status word, then let all zones drop out again
    task automatic run(logic [17:0] d, logic [7:0] s, int n, logic [31:0] x, logic [31:0] m);
        {zone_phase_detect, sig} <= {d, s};
        repeat (n) @(posedge hclk);
        rd(OFS_STATUS, x, m);
        {zone_phase_detect, sig} <= 26'h0;
        repeat (3) @(posedge hclk);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge hclk) begin
        if (rdp && hready) begin
            e = q.pop_front();
            cmp(hrdata, e[31:0], e[63:32]);
        end
        rdp <= hsel && htrans[1] && !hwrite && hready;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        end_of_test();
    end
    initial begin
        {hclk, hresetn, hsel, hwrite, sp_allow, ar_ready, rdp} = 7'h00;
        {haddr, hwdata, htrans, zone_phase_detect, sig, hsize} = 95'h2;
        void'($urandom(29));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_CTRL, 32'h2, 32'hFFFFFFFF);
        for (int i = 0; i < 9; i++) rd(OFS_DELAY0 + 12'(4 * i), 32'(DELAY_RESET[i*16 +: 16]), 32'hFFFF);
        xfer(1'b1, 12'h100, 32'hFFFFFFFF);
        rd(12'h100, 32'h0, 32'hFFFFFFFF);
        for (int i = 2; i < 7; i++) xfer(1'b1, OFS_DELAY0 + 12'(4 * i), (i < 4) ? 1 : (i == 4) ? 3 : 0);
        rd(OFS_DELAY0 + 12'h010, 32'h3, 32'hFFFF);
        sp_allow <= 1'b1;
        for (int p = 0; p < 3; p++) run(18'(1 << p), 8'h00, 4, 32'h1043 | (32'h4 << p), 32'h3FFFF);
        run(18'h00003, 8'h00, 4, 32'h63, 32'hFFF);
        sp_allow <= 1'b0;
        run(18'h00001, 8'h00, 4, 32'h22, 32'h3E);
        sp_allow <= 1'b1;
        run(18'h00008, 8'h00, 30, 32'hA2, 32'hFFE);
        xfer(1'b1, OFS_CTRL, 32'h3);
        run(18'h00008, 8'h00, 30, 32'h86, 32'hFFE);
        run(18'h00040, 8'h00, 20, 32'h0, 32'h2);
        run(18'h00040, 8'h00, 50, 32'h122, 32'hFFE);
        run(18'h00040, 8'h04, 3, 32'h22, 32'h3E);
        for (int z = 3; z < 5; z++) begin
            run(18'(1 << (3 * z)), 8'(1 << (4 - z)), 4, 32'h0, 32'h2);
            run(18'(1 << (3 * z)), 8'h00, 4, 32'h22 | (32'h40 << z), 32'hFFE);
        end
        run(18'h08000, 8'h00, 4, 32'h0, 32'h2);
        run(18'h08000, 8'h40, 4, 32'h806, 32'hFFE);
        ar_ready <= 1'b1;
        run(18'h08000, 8'h10, 4, 32'h2, 32'h2);
        cmp({31'h0, reclose_stage_release}, 32'h1, 32'h1);
        xfer(1'b1, OFS_CTRL, 32'h1);
        run(18'h08000, 8'h10, 4, 32'h0, 32'h2);
        ar_ready <= 1'b0;
        run(18'h08000, 8'h08, 4, 32'h0, 32'h2);
        xfer(1'b1, OFS_CTRL, 32'h19);
        run(18'h08000, 8'h08, 4, 32'h2, 32'h2);
        run(18'h18000, 8'h40, 4, 32'h806, 32'hFFE);
        run(18'h18000, 8'hC0, 4, 32'h822, 32'hFFE);
        xfer(1'b1, OFS_CTRL, 32'h1C);
        run(18'h18000, 8'h40, 4, 32'h0, 32'h2);
        run(18'h08000, 8'h40, 4, 32'h806, 32'hFFE);
        for (int k = 0; k < 20; k++) begin
            r = 3'($urandom);
            run({15'h0, r}, 8'h00, 4, (r == 3'h0) ? 32'h0 : ($countones(r) == 1) ?
                {27'h0, r, 2'h2} : 32'h22, 32'h3E);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
